// ===== pkg/usb_ep_pkg.sv
// Constants, types and state records for the endpoint transmit control block.
// Summary of operation
// - Endpoint 0 toggle picks DATA0 or DATA1
// - Endpoint 0 stall answers IN/OUT; SETUP clears
// - Endpoint 0 IN NAKed unless enabled, not done
// - Endpoint 0 OUT NAKed unless enabled, not done; ACKed at once when auto status is set
// - Four-bit byte counts in bits 3..0
// - Shared toggle picks DATA0 or DATA1
// - Select bit routes shared buffer to 1/2
// - Endpoint 2 IN NAKed when select shows 0
// - Shared IN NAKed unless enabled, not done
// - Force resume drives K onto lines
// - Forced resume never sets resume-detected flag
// - Endpoint 0 transmit done set on ACK
// - Endpoint 0 receive done set after ACK
// - Shared transmit done set on ACK
// - Control register enables and stalls endpoints
`default_nettype none
package usb_ep_pkg;
  localparam logic [7:0] ADDR_EP0_CTRL  = 8'hea;
  localparam logic [7:0] ADDR_EP12_CTRL = 8'heb;
  localparam logic [7:0] ADDR_GEN_CTRL  = 8'hec;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [7:0] GEN_CTRL_MASK  = 8'h1f;
  // Bit positions in the two transmit control registers and the general control register.
  localparam int BIT_TOGGLE  = 7;
  localparam int BIT_EP0_FORCE_STALL  = 6;
  localparam int BIT_SELECT  = 6;
  localparam int BIT_TX_EN   = 5;
  localparam int BIT_RX_EN   = 4;
  localparam int BIT_RESUME  = 4;
  localparam int BIT_AUTO_ST = 4;
  localparam int BIT_EP2_EN  = 3;
  localparam int BIT_EP1_EN  = 2;
  localparam int BIT_EP2_FORCE_STALL  = 1;
  localparam int BIT_EP1_FORCE_STALL  = 0;
  localparam int CNT_W       = 4;

  typedef enum logic [1:0] {
    TOK_OUT   = 2'b00,
    TOK_IN    = 2'b01,
    TOK_SETUP = 2'b10
  } token_t;

  typedef enum logic [2:0] {
    RESP_NAK   = 3'b000,
    RESP_STALL = 3'b001,
    RESP_ACK   = 3'b010,
    RESP_DATA0 = 3'b011,
    RESP_DATA1 = 3'b100
  } resp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WACK = 2'b10,
    ST_RECV = 2'b11
  } ctl_state_t;

  typedef struct packed {
    logic       valid;
    token_t     kind;
    logic [1:0] ep;
  } token_req_t;

  typedef struct packed {
    logic  valid;
    resp_t kind;
  } answer_t;

  typedef struct packed {
    logic [7:0] ep0_ctrl;
    logic [7:0] ep12_ctrl;
    logic [7:0] gen_ctrl;
    logic       ep0_tx_done_flag;
    logic       ep0_rx_done_flag;
    logic       ep12_tx_done_flag;
    logic       resume_detect_flag;
    ctl_state_t state;
    logic       cur_ep12;
    logic       start;
    answer_t    answer;
    logic [7:0] rdata;
  } ctl_regs_t;

  typedef struct packed {
    logic             active;
    logic [CNT_W-1:0] idx;
    logic [CNT_W-1:0] count;
    logic             valid;
    logic [7:0]       data;
    logic             done;
  } stream_regs_t;
endpackage : usb_ep_pkg
`default_nettype wire

// ===== rtl/usb_tx_streamer.sv
// Byte streamer that plays out a programmed number of buffer bytes.
`default_nettype none
`timescale 1ns/1ps
module usb_tx_streamer
  import usb_ep_pkg::*;
(
  // Clock and reset.
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  // Start request.
  input  wire logic             start_i,
  input  wire logic [CNT_W-1:0] count_i,
  // Buffer read port.
  output logic      [CNT_W-1:0] buf_index_o,
  input  wire logic [7:0]       buf_data_i,
  // Byte stream.
  output logic                  byte_valid_o,
  output logic      [7:0]       byte_o,
  input  wire logic             byte_ready_i,
  output logic                  done_o
);
  stream_regs_t s_q;
  stream_regs_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (start_i) begin
      s_d.idx    = '0;
      s_d.count  = count_i;
      s_d.valid  = 1'b0;
      s_d.active = (count_i != '0);
      s_d.done   = (count_i == '0);
    end else if (s_q.active && !s_q.valid) begin
      s_d.data  = buf_data_i;
      s_d.valid = 1'b1;
      s_d.idx   = s_q.idx + 1'b1;
    end else if (s_q.valid && byte_ready_i) begin
      s_d.valid = 1'b0;
      if (s_q.idx == s_q.count) begin
        s_d.active = 1'b0;
        s_d.done   = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign buf_index_o  = s_q.idx;
  assign byte_valid_o = s_q.valid;
  assign byte_o       = s_q.data;
  assign done_o       = s_q.done;

  a_byte_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
    s_q.valid && !byte_ready_i && !start_i |=> s_q.valid && $stable(s_q.data))
    else $error("Byte changed before it was taken.");
  a_count_end: assert property (@(posedge clock_i) disable iff (!rstn_i)
    s_q.done && !$past(start_i) |-> $past(s_q.idx) == $past(s_q.count))
    else $error("Stream ended on the wrong byte count.");
endmodule // usb_tx_streamer
`default_nettype wire

// ===== rtl/usb_ep_ctrl.sv
// Endpoint transmit control: control registers, token answers and byte play-out.
`default_nettype none
`timescale 1ns/1ps
module usb_ep_ctrl
  import usb_ep_pkg::*;
(
  // Clock and reset.
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  // Special function register port.
  input  wire logic [7:0]       sfr_addr_i,
  input  wire logic             sfr_wr_i,
  input  wire logic [7:0]       sfr_wdata_i,
  output logic      [7:0]       sfr_rdata_o,
  // Flag clears from the status register, one-cycle pulses.
  input  wire logic             ep0_tx_done_clr_i,
  input  wire logic             ep0_rx_done_clr_i,
  input  wire logic             ep12_tx_done_clr_i,
  input  wire logic             resume_detect_clr_i,
  // Flags.
  output logic                  ep0_tx_done_flag_o,
  output logic                  ep0_rx_done_flag_o,
  output logic                  ep12_tx_done_flag_o,
  output logic                  resume_detect_flag_o,
  // Serial engine events.
  input  wire token_req_t       token_i,
  input  wire logic             host_ack_i,
  input  wire logic             host_timeout_i,
  input  wire logic             rx_packet_ok_i,
  input  wire logic             bus_activity_i,
  input  wire logic             suspended_i,
  // Answers and transmit data.
  output answer_t               answer_o,
  output logic                  buf_ep12_o,
  output logic      [CNT_W-1:0] buf_index_o,
  input  wire logic [7:0]       buf_data_i,
  output logic                  byte_valid_o,
  output logic      [7:0]       byte_o,
  input  wire logic             byte_ready_i,
  output logic                  packet_end_o,
  // Data line drive for remote wake-up.
  output logic                  dp_o,
  output logic                  dp_oe_o,
  output logic                  dm_o,
  output logic                  dm_oe_o
);
  ctl_regs_t r_q;
  ctl_regs_t r_d;
  logic      stream_done;

  logic       ep0_tx_toggle;
  logic       ep0_force_stall;
  logic       ep0_tx_enable;
  logic       ep0_rx_enable;
  logic       ep12_tx_toggle;
  logic       ep12_buffer_select;
  logic       ep12_tx_enable;
  logic       force_resume;
  logic       auto_status_out;
  logic       ep1_enable;
  logic       ep2_enable;
  logic       ep1_force_stall;
  logic       ep2_force_stall;
  logic [CNT_W-1:0] ep0_tx_count;
  logic [CNT_W-1:0] ep12_tx_count;

  assign ep0_tx_toggle      = r_q.ep0_ctrl[BIT_TOGGLE];
  assign ep0_force_stall    = r_q.ep0_ctrl[BIT_EP0_FORCE_STALL];
  assign ep0_tx_enable      = r_q.ep0_ctrl[BIT_TX_EN];
  assign ep0_rx_enable      = r_q.ep0_ctrl[BIT_RX_EN];
  assign ep0_tx_count       = r_q.ep0_ctrl[CNT_W-1:0];
  assign ep12_tx_toggle     = r_q.ep12_ctrl[BIT_TOGGLE];
  assign ep12_buffer_select = r_q.ep12_ctrl[BIT_SELECT];
  assign ep12_tx_enable     = r_q.ep12_ctrl[BIT_TX_EN];
  assign force_resume       = r_q.ep12_ctrl[BIT_RESUME];
  assign ep12_tx_count      = r_q.ep12_ctrl[CNT_W-1:0];
  assign auto_status_out    = r_q.gen_ctrl[BIT_AUTO_ST];
  assign ep2_enable         = r_q.gen_ctrl[BIT_EP2_EN];
  assign ep1_enable         = r_q.gen_ctrl[BIT_EP1_EN];
  assign ep2_force_stall    = r_q.gen_ctrl[BIT_EP2_FORCE_STALL];
  assign ep1_force_stall    = r_q.gen_ctrl[BIT_EP1_FORCE_STALL];

  always_comb begin
    r_d        = r_q;
    r_d.start  = 1'b0;
    r_d.answer = '0;
    // Software writes first, so hardware updates below take priority.
    if (sfr_wr_i) begin
      unique case (sfr_addr_i)
        ADDR_EP0_CTRL:  r_d.ep0_ctrl  = sfr_wdata_i;
        ADDR_EP12_CTRL: r_d.ep12_ctrl = sfr_wdata_i;
        ADDR_GEN_CTRL:  r_d.gen_ctrl  = sfr_wdata_i & GEN_CTRL_MASK;
        default:        r_d.ep0_ctrl  = r_q.ep0_ctrl;
      endcase
    end
    if (ep0_tx_done_clr_i) r_d.ep0_tx_done_flag = 1'b0;
    if (ep0_rx_done_clr_i) r_d.ep0_rx_done_flag = 1'b0;
    if (ep12_tx_done_clr_i) r_d.ep12_tx_done_flag = 1'b0;
    if (resume_detect_clr_i) r_d.resume_detect_flag = 1'b0;
    // Our own K state looks like bus activity, so it must not count as a wake-up.
    if (bus_activity_i && suspended_i && !force_resume) begin
      r_d.resume_detect_flag = 1'b1;
    end

    unique case (r_q.state)
      ST_IDLE: begin
        if (token_i.valid && token_i.kind == TOK_SETUP && token_i.ep == 2'd0) begin
          // A write setting the stall in this very cycle still loses to SETUP.
          r_d.ep0_ctrl[BIT_EP0_FORCE_STALL] = 1'b0;
          r_d.state                = ST_RECV;
        end else if (token_i.valid && token_i.kind == TOK_IN) begin
          r_d.answer.valid = 1'b1;
          r_d.answer.kind  = RESP_NAK;
          if (token_i.ep == 2'd0) begin
            if (ep0_force_stall) begin
              r_d.answer.kind = RESP_STALL;
            end else if (ep0_tx_enable && !r_q.ep0_tx_done_flag) begin
              r_d.answer.kind = ep0_tx_toggle ? RESP_DATA1 : RESP_DATA0;
              r_d.cur_ep12    = 1'b0;
              r_d.start       = 1'b1;
              r_d.state       = ST_SEND;
            end
          end else if ((token_i.ep == 2'd1 && !ep1_enable)
                       || (token_i.ep == 2'd2 && !ep2_enable) || token_i.ep == 2'd3) begin
            // A disabled or absent endpoint stays silent, as if not addressed.
            r_d.answer.valid = 1'b0;
          end else if ((token_i.ep == 2'd1 && ep1_force_stall)
                       || (token_i.ep == 2'd2 && ep2_force_stall)) begin
            r_d.answer.kind = RESP_STALL;
          end else if (ep12_tx_enable && !r_q.ep12_tx_done_flag
                       && (ep12_buffer_select == (token_i.ep == 2'd2))) begin
            r_d.answer.kind = ep12_tx_toggle ? RESP_DATA1 : RESP_DATA0;
            r_d.cur_ep12    = 1'b1;
            r_d.start       = 1'b1;
            r_d.state       = ST_SEND;
          end
        end else if (token_i.valid && token_i.kind == TOK_OUT) begin
          r_d.answer.valid = (token_i.ep != 2'd3);
          r_d.answer.kind  = RESP_STALL;
          if (token_i.ep == 2'd0 && !ep0_force_stall) begin
            r_d.answer.kind = RESP_NAK;
            if (auto_status_out) begin
              r_d.answer.kind = RESP_ACK;
            end else if (ep0_rx_enable && !r_q.ep0_rx_done_flag) begin
              r_d.answer.valid = 1'b0;
              r_d.state        = ST_RECV;
            end
          end
        end
      end
      ST_SEND: begin
        if (stream_done) r_d.state = ST_WACK;
      end
      ST_WACK: begin
        if (host_ack_i) begin
          if (r_q.cur_ep12) r_d.ep12_tx_done_flag = 1'b1;
          else r_d.ep0_tx_done_flag = 1'b1;
          r_d.state = ST_IDLE;
        end else if (host_timeout_i) begin
          r_d.state = ST_IDLE;
        end
      end
      ST_RECV: begin
        if (rx_packet_ok_i) begin
          r_d.answer.valid      = 1'b1;
          r_d.answer.kind       = RESP_ACK;
          r_d.ep0_rx_done_flag  = 1'b1;
          r_d.state             = ST_IDLE;
        end else if (host_timeout_i) begin
          r_d.state = ST_IDLE;
        end
      end
    endcase

    unique case (sfr_addr_i)
      ADDR_EP0_CTRL:  r_d.rdata = r_q.ep0_ctrl;
      ADDR_EP12_CTRL: r_d.rdata = r_q.ep12_ctrl;
      ADDR_GEN_CTRL:  r_d.rdata = r_q.gen_ctrl;
      default:        r_d.rdata = RESET_BYTE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  usb_tx_streamer u_streamer (
    .clock_i      (clock_i),
    .rstn_i       (rstn_i),
    .start_i      (r_q.start),
    .count_i      (r_q.cur_ep12 ? ep12_tx_count : ep0_tx_count),
    .buf_index_o  (buf_index_o),
    .buf_data_i   (buf_data_i),
    .byte_valid_o (byte_valid_o),
    .byte_o       (byte_o),
    .byte_ready_i (byte_ready_i),
    .done_o       (stream_done)
  );

  assign sfr_rdata_o          = r_q.rdata;
  assign ep0_tx_done_flag_o   = r_q.ep0_tx_done_flag;
  assign ep0_rx_done_flag_o   = r_q.ep0_rx_done_flag;
  assign ep12_tx_done_flag_o  = r_q.ep12_tx_done_flag;
  assign resume_detect_flag_o = r_q.resume_detect_flag;
  assign answer_o             = r_q.answer;
  assign buf_ep12_o           = r_q.cur_ep12;
  assign packet_end_o         = stream_done;
  // Low-speed K state: D+ low, D- high.
  assign dp_o                 = 1'b0;
  assign dm_o                 = force_resume;
  assign dp_oe_o              = force_resume;
  assign dm_oe_o              = force_resume;

  a_stall_in: assert property (@(posedge clock_i) disable iff (!rstn_i)
    token_i.valid && token_i.kind == TOK_IN && token_i.ep == 2'd0
    && ep0_force_stall && r_q.state == ST_IDLE |=> answer_o.valid && answer_o.kind == RESP_STALL)
    else $error("Stalled endpoint 0 did not answer STALL.");
  a_setup_clear: assert property (@(posedge clock_i) disable iff (!rstn_i)
    token_i.valid && token_i.kind == TOK_SETUP && token_i.ep == 2'd0
    && r_q.state == ST_IDLE |=> !ep0_force_stall)
    else $error("SETUP left the endpoint 0 stall set.");
  a_ep0_nak: assert property (@(posedge clock_i) disable iff (!rstn_i)
    token_i.valid && token_i.kind == TOK_IN && token_i.ep == 2'd0 && !ep0_force_stall
    && (!ep0_tx_enable || r_q.ep0_tx_done_flag) && r_q.state == ST_IDLE
    |=> answer_o.valid && answer_o.kind == RESP_NAK)
    else $error("Endpoint 0 IN was not NAKed.");
  a_out_nak: assert property (@(posedge clock_i) disable iff (!rstn_i)
    token_i.valid && token_i.kind == TOK_OUT && token_i.ep == 2'd0 && !ep0_force_stall
    && !auto_status_out && (!ep0_rx_enable || r_q.ep0_rx_done_flag) && r_q.state == ST_IDLE
    |=> answer_o.kind == RESP_NAK && r_q.state == ST_IDLE)
    else $error("Endpoint 0 OUT was not NAKed.");
  a_ep0_pid: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(r_q.start) && !r_q.cur_ep12
    |-> answer_o.kind == (ep0_tx_toggle ? RESP_DATA1 : RESP_DATA0))
    else $error("Endpoint 0 data PID does not follow its toggle.");
  a_sel_nak: assert property (@(posedge clock_i) disable iff (!rstn_i)
    token_i.valid && token_i.kind == TOK_IN && token_i.ep == 2'd2 && ep2_enable
    && !ep2_force_stall && !ep12_buffer_select && r_q.state == ST_IDLE
    |=> answer_o.kind == RESP_NAK ##1 r_q.state == ST_IDLE)
    else $error("Endpoint 2 IN not NAKed while buffer serves endpoint 1.");
  a_shared_nak: assert property (@(posedge clock_i) disable iff (!rstn_i)
    r_q.start && r_q.cur_ep12 |-> $past(ep12_tx_enable) && !$past(r_q.ep12_tx_done_flag))
    else $error("Shared buffer sent while disabled or done.");
  a_tx_done: assert property (@(posedge clock_i) disable iff (!rstn_i)
    r_q.state == ST_WACK && host_ack_i
    |=> (r_q.cur_ep12 ? ep12_tx_done_flag_o : ep0_tx_done_flag_o) && r_q.state == ST_IDLE)
    else $error("Transmit done flag missing after ACK.");
  a_rx_done: assert property (@(posedge clock_i) disable iff (!rstn_i)
    r_q.state == ST_RECV && rx_packet_ok_i |=> ep0_rx_done_flag_o && answer_o.kind == RESP_ACK)
    else $error("Receive done flag missing after ACK.");
  a_resume_k: assert property (@(posedge clock_i) disable iff (!rstn_i)
    force_resume |-> dm_o && !dp_o && dp_oe_o && dm_oe_o ##1 !$rose(resume_detect_flag_o))
    else $error("Forced resume wrong or set its own flag.");
endmodule // usb_ep_ctrl
`default_nettype wire

// ===== verification/usb_host_model.sv
// Host-side model that paces byte takes and acknowledges each data packet.
`default_nettype none
`timescale 1ns/1ps
module usb_host_model (
  // Clock.
  input  wire logic clock_i,
  // Data phase.
  input  wire logic packet_end_i,
  output logic      byte_ready_o,
  output logic      host_ack_o
);
  integer seed = 32'h344f;
  logic   ack_wait_q;
  // Outputs settle by the third clock edge, well inside the reset hold of the bench.
  // Random stalls prove the block holds a byte until it is taken.
  always @(posedge clock_i) begin
    byte_ready_o <= ($random(seed) & 3) != 0;
    ack_wait_q   <= packet_end_i;
    host_ack_o   <= ack_wait_q;
  end
endmodule // usb_host_model
`default_nettype wire

// ===== verification/usb_ep_ctrl_tb.sv
// Self-checking bench for the endpoint transmit control block.
`default_nettype none
`timescale 1ns/1ps
module usb_ep_ctrl_tb;
  import usb_ep_pkg::*;
  logic             clock_i = 1'b0;
  logic             rstn_i = 1'b0;
  logic [7:0]       sfr_addr_i = 8'h00;
  logic             sfr_wr_i = 1'b0;
  logic [7:0]       sfr_wdata_i = 8'h00;
  logic [7:0]       sfr_rdata_o;
  logic [3:0]       clr = 4'h0;
  logic [3:0]       flags;
  token_req_t       token_i = '0;
  logic             host_ack_i;
  logic             byte_ready_i;
  logic             rx_packet_ok_i = 1'b0;
  logic             bus_activity_i = 1'b0;
  logic             suspended_i = 1'b0;
  answer_t          answer_o;
  logic             buf_ep12_o;
  logic             byte_valid_o;
  logic             packet_end_o;
  logic [3:0]       line;
  logic [CNT_W-1:0] buf_index_o;
  logic [7:0]       buf_data_i;
  logic [7:0]       byte_o;
  logic [7:0]       mem0 [16];
  logic [7:0]       mem12 [16];
  resp_t            aq [$];
  logic [7:0]       bq [$];
  integer           seed = 32'h344f;
  integer           errors = 0;
  integer           tests_run = 0;
  integer           pends = 0;
  logic [3:0]       n;

  always #20 clock_i = ~clock_i;
  assign buf_data_i = buf_ep12_o ? mem12[buf_index_o] : mem0[buf_index_o];

  usb_ep_ctrl uut (
    .clock_i, .rstn_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o,
    .ep0_tx_done_clr_i(clr[3]), .ep0_rx_done_clr_i(clr[2]),
    .ep12_tx_done_clr_i(clr[1]), .resume_detect_clr_i(clr[0]),
    .ep0_tx_done_flag_o(flags[3]), .ep0_rx_done_flag_o(flags[2]),
    .ep12_tx_done_flag_o(flags[1]), .resume_detect_flag_o(flags[0]),
    .token_i, .host_ack_i, .host_timeout_i(1'b0), .rx_packet_ok_i,
    .bus_activity_i, .suspended_i, .answer_o, .buf_ep12_o, .buf_index_o,
    .buf_data_i, .byte_valid_o, .byte_o, .byte_ready_i, .packet_end_o,
    .dp_o(line[1]), .dp_oe_o(line[3]), .dm_o(line[0]), .dm_oe_o(line[2])
  );

  usb_host_model host (
    .clock_i, .packet_end_i(packet_end_o), .byte_ready_o(byte_ready_i),
    .host_ack_o(host_ack_i)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    sfr_addr_i  <= a;
    sfr_wdata_i <= d;
    sfr_wr_i    <= 1'b1;
    @(posedge clock_i);
    sfr_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    sfr_addr_i <= a;
    @(posedge clock_i);
    #1 chk(sfr_rdata_o, exp);
  endtask

  task automatic clear(input int i);
    @(posedge clock_i);
    clr[i] <= 1'b1;
    @(posedge clock_i);
    clr <= 4'h0;
  endtask

  task automatic tok(input token_t k, input logic [1:0] ep, input logic v, input resp_t r);
    @(posedge clock_i);
    token_i <= '{1'b1, k, ep};
    if (v)
      aq.push_back(r);
    @(posedge clock_i);
    token_i.valid <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask

  task automatic rxok;
    aq.push_back(RESP_ACK);
    @(posedge clock_i);
    rx_packet_ok_i <= 1'b1;
    @(posedge clock_i);
    rx_packet_ok_i <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask

  // The host acknowledges two cycles after the last byte, so wait past that.
  task automatic pkt(input logic [1:0] ep, input logic tg, input logic e12);
    integer p0;
    p0 = pends;
    for (int i = 0; i < n; i++)
      bq.push_back(e12 ? mem12[i] : mem0[i]);
    tok(TOK_IN, ep, 1'b1, tg ? RESP_DATA1 : RESP_DATA0);
    for (int w = 0; w < 400 && pends == p0; w++)
      @(posedge clock_i);
    repeat (5) @(posedge clock_i);
    chk(8'(pends - p0), 8'h01);
    chk(8'(bq.size()), 8'h00);
  endtask

  always @(posedge clock_i) begin
    if (answer_o.valid === 1'b1)
      chk({5'h00, answer_o.kind}, aq.size() ? {5'h00, aq.pop_front()} : 8'hff);
    if (byte_valid_o === 1'b1 && byte_ready_i === 1'b1)
      chk(byte_o, bq.size() ? bq.pop_front() : ~byte_o);
    if (packet_end_o === 1'b1)
      pends++;
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    end_sim();
  end

  initial begin
    for (int i = 0; i < 16; i++) begin
      mem0[i]  = 8'($random(seed));
      mem12[i] = 8'($random(seed));
    end
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    rd(ADDR_EP0_CTRL, RESET_BYTE);
    rd(ADDR_EP12_CTRL, RESET_BYTE);
    rd(ADDR_GEN_CTRL, RESET_BYTE);
    wr(ADDR_GEN_CTRL, 8'hff);
    rd(ADDR_GEN_CTRL, GEN_CTRL_MASK);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    wr(ADDR_GEN_CTRL, 8'h0c);
    tok(TOK_IN, 2'd0, 1'b1, RESP_NAK);
    for (int t = 0; t < 2; t++) begin
      n = t ? 4'hf : 4'($random(seed));
      wr(ADDR_EP0_CTRL, {t[0], 3'b010, n});
      rd(ADDR_EP0_CTRL, {t[0], 3'b010, n});
      pkt(2'd0, t[0], 1'b0);
      chk({7'h00, flags[3]}, 8'h01);
      tok(TOK_IN, 2'd0, 1'b1, RESP_NAK);
      clear(3);
      n = t ? 4'h0 : 4'($random(seed));
      // Select follows t, so the other endpoint must be refused first.
      wr(ADDR_EP12_CTRL, {t[0], t[0], 2'b10, n});
      tok(TOK_IN, t ? 2'd1 : 2'd2, 1'b1, RESP_NAK);
      pkt(t ? 2'd2 : 2'd1, t[0], 1'b1);
      chk({7'h00, flags[1]}, 8'h01);
      tok(TOK_IN, t ? 2'd2 : 2'd1, 1'b1, RESP_NAK);
      clear(1);
    end
    wr(ADDR_EP12_CTRL, 8'h00);
    tok(TOK_IN, 2'd1, 1'b1, RESP_NAK);
    wr(ADDR_EP0_CTRL, 8'h70);
    tok(TOK_IN, 2'd0, 1'b1, RESP_STALL);
    tok(TOK_OUT, 2'd0, 1'b1, RESP_STALL);
    tok(TOK_SETUP, 2'd0, 1'b0, RESP_ACK);
    rxok();
    rd(ADDR_EP0_CTRL, 8'h30);
    clear(2);
    tok(TOK_OUT, 2'd0, 1'b0, RESP_ACK);
    rxok();
    chk({7'h00, flags[2]}, 8'h01);
    tok(TOK_OUT, 2'd0, 1'b1, RESP_NAK);
    clear(2);
    wr(ADDR_EP0_CTRL, 8'h20);
    tok(TOK_OUT, 2'd0, 1'b1, RESP_NAK);
    // Automatic status answers OUT at once and leaves the receive flag alone.
    wr(ADDR_GEN_CTRL, 8'h10);
    tok(TOK_OUT, 2'd0, 1'b1, RESP_ACK);
    chk({7'h00, flags[2]}, 8'h00);
    wr(ADDR_EP12_CTRL, 8'h20);
    wr(ADDR_GEN_CTRL, 8'h0d);
    tok(TOK_IN, 2'd1, 1'b1, RESP_STALL);
    wr(ADDR_EP12_CTRL, 8'h60);
    wr(ADDR_GEN_CTRL, 8'h0e);
    tok(TOK_IN, 2'd2, 1'b1, RESP_STALL);
    wr(ADDR_GEN_CTRL, 8'h00);
    tok(TOK_IN, 2'd2, 1'b0, RESP_NAK);
    // The wake-up hold is far shorter than on a real bus to keep the run short.
    // Activity starts only once the forced resume is in place, as it would on a bus.
    wr(ADDR_EP12_CTRL, 8'h10);
    @(posedge clock_i);
    suspended_i    <= 1'b1;
    bus_activity_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    chk({4'h0, line}, 8'h0d);
    chk({7'h00, flags[0]}, 8'h00);
    wr(ADDR_EP12_CTRL, 8'h00);
    repeat (3) @(posedge clock_i);
    chk({4'h0, line[3:2], 2'b00}, 8'h00);
    chk({7'h00, flags[0]}, 8'h01);
    clear(0);
    chk(8'(aq.size() + bq.size()), 8'h00);
    end_sim();
  end
endmodule // usb_ep_ctrl_tb
`default_nettype wire
